//--- common/mrpe_pkg.sv
// package for the memory replay / page walk event selection block
// assumes an apb slave with 32-bit data and byte addresses
`default_nettype none
package mrpe_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_SP0    = 8'h00;
    localparam logic [7:0] OFF_SP1    = 8'h04;
    localparam logic [7:0] OFF_OB0    = 8'h08;
    localparam logic [7:0] OFF_OB1    = 8'h0c;
    localparam logic [7:0] OFF_PW0    = 8'h10;
    localparam logic [7:0] OFF_PW1    = 8'h14;
    localparam logic [7:0] OFF_CCFG   = 8'h18;
    localparam logic [7:0] OFF_STAT   = 8'h1c;
    localparam logic [7:0] OFF_MASK   = 8'h20;
    localparam logic [7:0] OFF_CNT    = 8'h24;
    // event control register fields and the store group field of the group config word
    localparam int SEL_LSB  = 25;
    localparam int SEL_W    = 7;
    localparam int CAUSE_LSB = 9;
    localparam int CAUSE_W  = 16;
    localparam int GRP_LSB  = 13;
    localparam int GRP_W    = 3;
    localparam int GRP_OB_LSB = 0; // ordering group field in the group config word
    localparam int GRP_PW_LSB = 4; // walk group field in the group config word
    // codes
    localparam logic [6:0] SEL_STORE_REPLAY = 7'h05;
    localparam logic [6:0] SEL_OB_REPLAY    = 7'h03;
    localparam logic [6:0] SEL_PAGE_WALK    = 7'h01;
    localparam logic [2:0] GRP_STORE        = 3'h2;
    localparam logic [2:0] GRP_OB           = 3'h2;
    localparam logic [2:0] GRP_PW           = 3'h4;
    // cause mask bits
    localparam logic [15:0] DEF_STORE = 16'h0002; // divided_store_cause
    localparam logic [15:0] DEF_OB    = 16'h003a; // bits 1,3,4,5
    localparam logic [15:0] DEF_PW    = 16'h0003; // bits 0,1
    localparam logic [31:0] RST_CTL   = 32'h0000_0000;
    localparam logic [11:0] PAGE_4K_MASK = 12'hfff;
    localparam int NUM_CTL = 6;
    localparam int NUM_EV  = 3;
endpackage : mrpe_pkg
`default_nettype wire

//--- common/mrpe_sel_if.sv
// carries one control word and the raw causes into a selector
// assumes the same clock as the register file
`timescale 1ns/10ps
`default_nettype none
interface mrpe_sel_if;
    logic [31:0] ctl;
    logic [2:0]  grp;
    logic [15:0] cause;
    logic        hit;
    modport host (output ctl, output grp, output cause, input hit);
    modport sel  (input ctl, input grp, input cause, output hit);
endinterface : mrpe_sel_if
`default_nettype wire

//--- rtl/mrpe_select.sv
// one event selector: code match, group match and masked cause or
// takes the raw causes from the caller; undefined bits drop out through the DEFS mask
`timescale 1ns/10ps
`default_nettype none
module mrpe_select #(
    parameter logic [6:0]  CODE  = mrpe_pkg::SEL_PAGE_WALK,
    parameter logic [2:0]  GROUP = mrpe_pkg::GRP_PW,
    parameter logic [15:0] DEFS  = mrpe_pkg::DEF_PW
) (
    mrpe_sel_if.sel s
);
    logic [15:0] m;
    // undefined mask bits never count
    always_comb begin
        m = s.ctl[mrpe_pkg::CAUSE_LSB +: mrpe_pkg::CAUSE_W] & DEFS;
        s.hit = (s.ctl[mrpe_pkg::SEL_LSB +: mrpe_pkg::SEL_W] == CODE)
              && (s.grp == GROUP)
              && |(m & s.cause);
    end
endmodule : mrpe_select
`default_nettype wire

//--- rtl/mrpe_top.sv
// Notes on behaviour
// - code 05h counts store-port replays, divided store
// - any selected cause of several counts
// - code 03h counts ordering-buffer load reissues, group 2
// - ordering mask bit 1: unknown store address
// - ordering mask bit 3: unknown store value
// - ordering mask bit 4: partial_overlap_cause overlap
// - ordering mask bit 5: low address mismatch
// - code 01h counts page walks, group 4
// - walk mask bit 0: data translation miss
// - walk mask bit 1: instruction translation miss
// - walk lookup treated as 4-KByte page
//
// apb slave with six event control registers, group config, status,
// mask and a counter; assumes causes are one-cycle pulses from the core
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module mrpe_top #(
    parameter int CNT_W = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        divided_store_cause,
    input  wire logic        at_retirement,
    input  wire logic [15:0] ordering_causes,
    input  wire logic        data_translation_miss_walk,
    input  wire logic        instruction_translation_miss_walk,
    input  wire logic [31:0] walk_address,
    output logic      [31:0] walk_page_base,
    output logic             irq
);
    typedef struct packed {
        logic [5:0][31:0] ctl;
        logic [31:0]      ccfg;   // three group fields, one per event
        logic [2:0]       stat;
        logic [2:0]       mask;
        logic [CNT_W-1:0] cnt;
        logic [31:0]      rdata;
        logic             ready;
        logic             err;
        logic [31:0]      pbase;
        logic             irq;
    } mrpe_state_type;

    mrpe_state_type st_r, st_nxt;
    mrpe_sel_if sif [3] ();
    logic [2:0] hit;

    function automatic logic [31:0] ctl_or(input logic [31:0] a, input logic [31:0] b);
        ctl_or = a | b;
    endfunction : ctl_or

    // store port: at retirement only the second control counts; otherwise both controls count
    assign sif[0].ctl   = at_retirement ? st_r.ctl[1] : ctl_or(st_r.ctl[0], st_r.ctl[1]);
    assign sif[0].grp   = st_r.ccfg[mrpe_pkg::GRP_LSB +: mrpe_pkg::GRP_W];
    assign sif[0].cause = {14'h0000, divided_store_cause, 1'b0};
    assign sif[1].ctl   = ctl_or(st_r.ctl[2], st_r.ctl[3]);
    assign sif[1].grp   = st_r.ccfg[mrpe_pkg::GRP_OB_LSB +: mrpe_pkg::GRP_W];
    // bits 1,3,4,5 cover the four ordering causes
    assign sif[1].cause = ordering_causes;
    assign sif[2].ctl   = ctl_or(st_r.ctl[4], st_r.ctl[5]);
    assign sif[2].grp   = st_r.ccfg[mrpe_pkg::GRP_PW_LSB +: mrpe_pkg::GRP_W];
    assign sif[2].cause = {14'h0000, instruction_translation_miss_walk,
                           data_translation_miss_walk};

    mrpe_select #(.CODE(mrpe_pkg::SEL_STORE_REPLAY), .GROUP(mrpe_pkg::GRP_STORE),
                  .DEFS(mrpe_pkg::DEF_STORE)) u_sp (.s(sif[0]));
    mrpe_select #(.CODE(mrpe_pkg::SEL_OB_REPLAY), .GROUP(mrpe_pkg::GRP_OB),
                  .DEFS(mrpe_pkg::DEF_OB)) u_ob (.s(sif[1]));
    mrpe_select #(.CODE(mrpe_pkg::SEL_PAGE_WALK), .GROUP(mrpe_pkg::GRP_PW),
                  .DEFS(mrpe_pkg::DEF_PW)) u_pw (.s(sif[2]));

    assign hit = {sif[2].hit, sif[1].hit, sif[0].hit};

    // next state: bus access, sticky status, counting
    always_comb begin
        st_nxt = st_r;
        st_nxt.ready = 1'b0;
        st_nxt.err = 1'b0;
        st_nxt.cnt = st_r.cnt + CNT_W'(hit[0]) + CNT_W'(hit[1]) + CNT_W'(hit[2]);
        // every counted walk looked up as a 4-KByte page
        if (|hit[2]) begin
            st_nxt.pbase = walk_address & ~{20'h00000, mrpe_pkg::PAGE_4K_MASK};
        end
        if (psel && !penable) begin
            st_nxt.ready = 1'b1;
            st_nxt.rdata = 32'h0000_0000;
            unique case (paddr)
                mrpe_pkg::OFF_SP0: st_nxt.rdata = st_r.ctl[0];
                mrpe_pkg::OFF_SP1: st_nxt.rdata = st_r.ctl[1];
                mrpe_pkg::OFF_OB0: st_nxt.rdata = st_r.ctl[2];
                mrpe_pkg::OFF_OB1: st_nxt.rdata = st_r.ctl[3];
                mrpe_pkg::OFF_PW0: st_nxt.rdata = st_r.ctl[4];
                mrpe_pkg::OFF_PW1: st_nxt.rdata = st_r.ctl[5];
                mrpe_pkg::OFF_CCFG: st_nxt.rdata = st_r.ccfg;
                mrpe_pkg::OFF_STAT: st_nxt.rdata = {29'h0, st_r.stat};
                mrpe_pkg::OFF_MASK: st_nxt.rdata = {29'h0, st_r.mask};
                mrpe_pkg::OFF_CNT:  st_nxt.rdata = 32'(st_r.cnt);
                default: st_nxt.err = 1'b1;
            endcase
        end
        if (psel && penable && st_r.ready && pwrite) begin
            unique case (paddr)
                mrpe_pkg::OFF_SP0: st_nxt.ctl[0] = pwdata;
                mrpe_pkg::OFF_SP1: st_nxt.ctl[1] = pwdata;
                mrpe_pkg::OFF_OB0: st_nxt.ctl[2] = pwdata;
                mrpe_pkg::OFF_OB1: st_nxt.ctl[3] = pwdata;
                mrpe_pkg::OFF_PW0: st_nxt.ctl[4] = pwdata;
                mrpe_pkg::OFF_PW1: st_nxt.ctl[5] = pwdata;
                mrpe_pkg::OFF_CCFG: st_nxt.ccfg = pwdata;
                mrpe_pkg::OFF_STAT: st_nxt.stat = st_r.stat & ~pwdata[2:0];
                mrpe_pkg::OFF_MASK: st_nxt.mask = pwdata[2:0];
                mrpe_pkg::OFF_CNT:  st_nxt.cnt = CNT_W'(pwdata);
                default: ;
            endcase
        end
        // set wins over write-one-to-clear
        st_nxt.stat = st_nxt.stat | hit;
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    end

    // single register for all state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.err;
    assign walk_page_base = st_r.pbase;
    assign irq = st_r.irq;

    // page walk with group 4 counts
    pw_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        sif[2].hit |=> st_r.stat[2]) else $error("walk not flagged");
    ob_group_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sif[1].grp != mrpe_pkg::GRP_OB) |-> !sif[1].hit)
        else $error("ordering hit with wrong group");
    undef_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sif[2].cause[1:0] == 2'h0) |-> !sif[2].hit)
        else $error("undefined walk bit counted");
    page_base_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit[2] |=> walk_page_base[11:0] == 12'h000)
        else $error("walk base not 4k");
    sp_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        sif[0].hit |-> sif[0].ctl[31:25] == mrpe_pkg::SEL_STORE_REPLAY)
        else $error("store hit wrong code");
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready) else $error("no ready");
    irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.mask == 3'h0) |-> !irq) else $error("masked irq");
    ob_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sif[1].cause & mrpe_pkg::DEF_OB) == 16'h0 |-> !sif[1].hit)
        else $error("ordering undefined bit counted");

    // decoded fields of the merged controls, for the checks below only
    logic [6:0]  sp_code, ob_code, pw_code;
    logic [15:0] sp_mask, ob_mask, pw_mask;
    logic        ob_sel, pw_sel, stat_wr;
    assign sp_code = sif[0].ctl[mrpe_pkg::SEL_LSB +: mrpe_pkg::SEL_W];
    assign ob_code = sif[1].ctl[mrpe_pkg::SEL_LSB +: mrpe_pkg::SEL_W];
    assign pw_code = sif[2].ctl[mrpe_pkg::SEL_LSB +: mrpe_pkg::SEL_W];
    assign sp_mask = sif[0].ctl[mrpe_pkg::CAUSE_LSB +: mrpe_pkg::CAUSE_W];
    assign ob_mask = sif[1].ctl[mrpe_pkg::CAUSE_LSB +: mrpe_pkg::CAUSE_W];
    assign pw_mask = sif[2].ctl[mrpe_pkg::CAUSE_LSB +: mrpe_pkg::CAUSE_W];
    // code and group both right: the selector is armed
    assign ob_sel  = (ob_code == mrpe_pkg::SEL_OB_REPLAY) && (sif[1].grp == mrpe_pkg::GRP_OB);
    assign pw_sel  = (pw_code == mrpe_pkg::SEL_PAGE_WALK) && (sif[2].grp == mrpe_pkg::GRP_PW);
    // committed status write, the only way a sticky bit may fall
    assign stat_wr = psel && penable && pready && pwrite && (paddr == mrpe_pkg::OFF_STAT);

    // store port selector
    sp_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        sif[0].hit |-> divided_store_cause && sp_mask[1])
        else $error("store hit without selected cause");
    sp_group_a: assert property (@(posedge pclk) disable iff (!presetn)
        sif[0].hit |-> sif[0].grp == mrpe_pkg::GRP_STORE)
        else $error("store hit with wrong group");
    sp_retire_a: assert property (@(posedge pclk) disable iff (!presetn)
        (at_retirement && sif[0].hit)
        |-> st_r.ctl[1][mrpe_pkg::SEL_LSB +: mrpe_pkg::SEL_W] == mrpe_pkg::SEL_STORE_REPLAY)
        else $error("retirement hit not from second control");

    // ordering buffer selector: each cause counts alone
    ob_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        sif[1].hit |-> ob_sel) else $error("ordering hit with wrong code");
    ob_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ob_sel && ob_mask[1] && ordering_causes[1]) |-> sif[1].hit)
        else $error("unknown address cause missed");
    ob_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ob_sel && ob_mask[3] && ordering_causes[3]) |-> sif[1].hit)
        else $error("unknown value cause missed");
    ob_part_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ob_sel && ob_mask[4] && ordering_causes[4]) |-> sif[1].hit)
        else $error("partial overlap cause missed");
    ob_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ob_sel && ob_mask[5] && ordering_causes[5]) |-> sif[1].hit)
        else $error("low address cause missed");
    ob_any_a: assert property (@(posedge pclk) disable iff (!presetn)
        sif[1].hit |-> |(ob_mask & ordering_causes & mrpe_pkg::DEF_OB))
        else $error("ordering hit without selected cause");

    // page walk selector
    pw_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        sif[2].hit |-> pw_sel) else $error("walk hit with wrong code");
    pw_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pw_sel && pw_mask[0] && data_translation_miss_walk) |-> sif[2].hit)
        else $error("data miss walk missed");
    pw_inst_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pw_sel && pw_mask[1] && instruction_translation_miss_walk) |-> sif[2].hit)
        else $error("instruction miss walk missed");
    pw_base_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit[2] |=> walk_page_base[31:12] == $past(walk_address[31:12]))
        else $error("walk base lost page number");
    pw_undef_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pw_mask & mrpe_pkg::DEF_PW) == 16'h0000 |-> !sif[2].hit)
        else $error("walk counted on undefined bit");

    // status stays set until software clears it; irq follows status and mask
    stat_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.stat[2] && !stat_wr) |=> st_r.stat[2])
        else $error("walk status dropped");
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(st_r.stat & st_r.mask)) else $error("irq not status and mask");
    err_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready) else $error("error without ready");

    // read data taken from the registers as they stood at setup
    rd_sp0_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == mrpe_pkg::OFF_SP0) |=> prdata == $past(st_r.ctl[0]))
        else $error("first store control read wrong");
    rd_sp1_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == mrpe_pkg::OFF_SP1) |=> prdata == $past(st_r.ctl[1]))
        else $error("second store control read wrong");
    rd_ob0_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == mrpe_pkg::OFF_OB0) |=> prdata == $past(st_r.ctl[2]))
        else $error("first ordering control read wrong");
    rd_ob1_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == mrpe_pkg::OFF_OB1) |=> prdata == $past(st_r.ctl[3]))
        else $error("second ordering control read wrong");
    rd_pw0_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == mrpe_pkg::OFF_PW0) |=> prdata == $past(st_r.ctl[4]))
        else $error("first walk control read wrong");
    rd_pw1_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == mrpe_pkg::OFF_PW1) |=> prdata == $past(st_r.ctl[5]))
        else $error("second walk control read wrong");
    rd_ccfg_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == mrpe_pkg::OFF_CCFG) |=> prdata == $past(st_r.ccfg))
        else $error("group config read wrong");

    // main scenarios seen at least once
    cov_sp_c: cover property (@(posedge pclk) sif[0].hit);
    cov_ob_c: cover property (@(posedge pclk) sif[1].hit);
    cov_pw_c: cover property (@(posedge pclk) sif[2].hit);
    cov_irq_c: cover property (@(posedge pclk) $rose(irq));
    cov_err_c: cover property (@(posedge pclk) pslverr);
endmodule : mrpe_top
`default_nettype wire

//--- tb/tb_mrpe_top.sv
// self-checking bench for the replay and page walk event selector
// assumes the apb map and one-cycle event latency given by the designer
`timescale 1ns/10ps
`default_nettype none
module tb_mrpe_top;
    typedef struct packed {
        logic [2:0]  idx;
        logic [6:0]  code;
        logic [15:0] mask;
        logic [15:0] ccfg;
        logic        st;
        logic        rt;
        logic [15:0] ob;
        logic        dt;
        logic        it;
        logic [2:0]  stat;
    } mrpe_row_type;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, walk_address = 32'h0, prdata, walk_page_base, rd;
    logic        st = 1'h0, rt = 1'h0, dt = 1'h0, it = 1'h0, pready, pslverr, irq, er;
    logic [15:0] ob = 16'h0;
    int          n_fail = 0, n_compared = 0;
    mrpe_row_type rows [14] = '{
        '{3'h0, 7'h05, 16'h0002, 16'h4042, 1'h1, 1'h0, 16'h0, 1'h0, 1'h0, 3'h1},
        '{3'h0, 7'h05, 16'h0002, 16'h4042, 1'h1, 1'h1, 16'h0, 1'h0, 1'h0, 3'h0},
        '{3'h1, 7'h05, 16'h0002, 16'h4042, 1'h1, 1'h1, 16'h0, 1'h0, 1'h0, 3'h1},
        '{3'h2, 7'h03, 16'h0002, 16'h4042, 1'h0, 1'h0, 16'h2, 1'h0, 1'h0, 3'h2},
        '{3'h3, 7'h03, 16'h0008, 16'h4042, 1'h0, 1'h0, 16'h8, 1'h0, 1'h0, 3'h2},
        '{3'h2, 7'h03, 16'h0010, 16'h4042, 1'h0, 1'h0, 16'h10, 1'h0, 1'h0, 3'h2},
        '{3'h2, 7'h03, 16'h0020, 16'h4042, 1'h0, 1'h0, 16'h20, 1'h0, 1'h0, 3'h2},
        '{3'h2, 7'h03, 16'h003a, 16'h4042, 1'h0, 1'h0, 16'h20, 1'h0, 1'h0, 3'h2},
        '{3'h2, 7'h03, 16'h0002, 16'h4042, 1'h0, 1'h0, 16'h8, 1'h0, 1'h0, 3'h0},
        '{3'h2, 7'h03, 16'h0004, 16'h4042, 1'h0, 1'h0, 16'h4, 1'h0, 1'h0, 3'h0},
        '{3'h2, 7'h03, 16'h0002, 16'h4043, 1'h0, 1'h0, 16'h2, 1'h0, 1'h0, 3'h0},
        '{3'h4, 7'h01, 16'h0001, 16'h4042, 1'h0, 1'h0, 16'h0, 1'h1, 1'h0, 3'h4},
        '{3'h5, 7'h01, 16'h0002, 16'h4042, 1'h0, 1'h0, 16'h0, 1'h0, 1'h1, 3'h4},
        '{3'h4, 7'h01, 16'h0001, 16'h4022, 1'h0, 1'h0, 16'h0, 1'h1, 1'h0, 3'h0}
    };
    mrpe_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .divided_store_cause(st), .at_retirement(rt),
        .ordering_causes(ob), .data_translation_miss_walk(dt),
        .instruction_translation_miss_walk(it), .walk_address(walk_address),
        .walk_page_base(walk_page_base), .irq(irq));
    // 200 mhz clock
    always #2.5 pclk = ~pclk;
    // one apb transfer; waits on pready, bounded so a dead slave cannot hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1 && ++k < 50);
        if (pready !== 1'h1) n_fail++; // a slave that never answers is a mismatch
        rd = prdata;
        er = pslverr;
        psel <= 1'h0; penable <= 1'h0;
    endtask : apb
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_word
    task automatic chk_bit(input logic g, input logic e);
        chk_word({31'h0, g}, {31'h0, e});
    endtask : chk_bit
    task automatic test_done;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200us;
        n_fail++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(negedge pclk);
        chk_bit(pready, 1'h0);
        chk_bit(irq, 1'h0);
        chk_word(prdata, 32'h0);
        chk_word(walk_page_base, 32'h0);
        $display("reset test done");
        // table of selections: clear, program, one pulse, read back
        foreach (rows[i]) begin
            for (int j = 0; j < 6; j++) apb(1'h1, 8'(4 * j), 32'h0);
            apb(1'h1, mrpe_pkg::OFF_CCFG, {16'h0, rows[i].ccfg});
            apb(1'h1, 8'(4 * rows[i].idx), {rows[i].code, rows[i].mask, 9'h0});
            apb(1'h1, mrpe_pkg::OFF_STAT, 32'h7);
            apb(1'h1, mrpe_pkg::OFF_CNT, 32'h0);
            st <= rows[i].st; rt <= rows[i].rt; ob <= rows[i].ob;
            dt <= rows[i].dt; it <= rows[i].it;
            @(posedge pclk);
            st <= 1'h0; ob <= 16'h0; dt <= 1'h0; it <= 1'h0;
            apb(1'h0, mrpe_pkg::OFF_STAT, 32'h0);
            chk_word(rd, {29'h0, rows[i].stat});
            apb(1'h0, mrpe_pkg::OFF_CNT, 32'h0);
            chk_word(rd, {31'h0, rows[i].stat != 3'h0});
            chk_bit(irq, 1'h0); // status masked off
            $display("row %0d done", i);
        end
        // unmapped place: refused, write lost, reads zero
        apb(1'h1, 8'h40, 32'hffff_ffff);
        chk_bit(er, 1'h1);
        apb(1'h0, 8'h40, 32'h0);
        chk_bit(er, 1'h1);
        chk_word(rd, 32'h0);
        $display("unmapped test done");
        // interrupt raise, mask, clear; walk base forced to a 4k page
        apb(1'h1, mrpe_pkg::OFF_CCFG, 32'h4042);
        apb(1'h1, mrpe_pkg::OFF_PW0, {7'h01, 16'h0001, 9'h0});
        apb(1'h1, mrpe_pkg::OFF_STAT, 32'h7);
        apb(1'h1, mrpe_pkg::OFF_MASK, 32'h4);
        walk_address <= 32'h1234_5abc; dt <= 1'h1;
        @(posedge pclk);
        dt <= 1'h0;
        repeat (2) @(negedge pclk);
        chk_bit(irq, 1'h1);
        chk_word(walk_page_base, 32'h1234_5000);
        apb(1'h1, mrpe_pkg::OFF_MASK, 32'h0);
        repeat (2) @(negedge pclk);
        chk_bit(irq, 1'h0);
        apb(1'h1, mrpe_pkg::OFF_MASK, 32'h4);
        repeat (2) @(negedge pclk);
        chk_bit(irq, 1'h1);
        apb(1'h1, mrpe_pkg::OFF_STAT, 32'h4);
        repeat (2) @(negedge pclk);
        chk_bit(irq, 1'h0);
        $display("interrupt test done");
        test_done();
    end
endmodule : tb_mrpe_top
`default_nettype wire
